// >>> sac_adc_ctrl.sv
// successive-approximation converter control: registers, sequencer, pin control
`timescale 1ns/1ps
module sac_adc_ctrl #(
  parameter int OSC_DIV = 20  // system clocks per converter clock period fx
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // register access
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // system options
  input  wire logic        osc_mode_bit,
  input  wire logic [7:0]  port_pullup_req,
  // external trigger, already edge-qualified pulse
  input  wire logic        ext_trigger_input,
  // analog front end
  input  wire logic        comparator_out,
  output logic      [7:0]  tap_code,
  output logic      [2:0]  analog_channel,
  output logic             sample_hold,
  output logic             analog_power,
  // pin control
  output logic      [7:0]  analog_pin_en,
  output logic      [7:0]  pullup_en,
  // done interrupt, one-cycle pulse
  output logic             conv_done_irq
);
  initial begin
    if (OSC_DIV < 1 || OSC_DIV > 255) $error("OSC_DIV out of range");
  end

  // ============================================================
  // register decode
  wire wr_mode   = reg_wr && reg_addr == sac_pkg::SAC_MODE_ADDR;
  wire wr_pinsel = reg_wr && reg_addr == sac_pkg::SAC_PINSEL_ADDR;
  wire rd_mode   = reg_addr == sac_pkg::SAC_MODE_ADDR;
  wire rd_result = reg_addr == sac_pkg::SAC_RESULT_ADDR;
  wire rd_pinsel = reg_addr == sac_pkg::SAC_PINSEL_ADDR;

  logic [7:0]         conv_mode_reg;
  logic [7:0]         conv_result_reg;
  logic [7:0]         analog_pin_select_reg;
  logic [7:0]         approx_shift_reg;
  logic [7:0]         trial_bit_reg;
  logic [7:0]         step_cnt_reg;
  logic [7:0]         div_cnt_reg;
  logic               armed_reg;
  sac_pkg::sac_state_e state_reg;
  sac_pkg::sac_state_e state_next;

  sac_pkg::sac_mode_s mode;
  assign mode = sac_pkg::sac_mode_s'(conv_mode_reg);

  // ============================================================
  // conversion length, in fx periods per conversion
  logic [7:0] conv_len;
  always_comb begin
    case ({mode.fr, mode.high_speed_time_bit})
      3'b000:  conv_len = osc_mode_bit ? sac_pkg::SAC_LEN_80  : sac_pkg::SAC_LEN_160;
      3'b001:  conv_len = osc_mode_bit ? sac_pkg::SAC_LEN_40  : sac_pkg::SAC_LEN_80;
      3'b011:  conv_len = osc_mode_bit ? sac_pkg::SAC_LEN_50  : sac_pkg::SAC_LEN_100;
      3'b110:  conv_len = osc_mode_bit ? sac_pkg::SAC_LEN_100 : sac_pkg::SAC_LEN_200;
      default: conv_len = osc_mode_bit ? sac_pkg::SAC_LEN_100 : sac_pkg::SAC_LEN_200;
    endcase
  end
  // sampling takes the remainder after eight equal bit steps
  wire [7:0] bit_len    = conv_len >> 4;
  wire [7:0] sample_len = conv_len - (bit_len << 3);

  // fx enable: divide system clock
  wire fx_tick = div_cnt_reg == 8'(OSC_DIV - 1);
  wire step_end = fx_tick && step_cnt_reg == 8'h00;

  // ============================================================
  // sequencer
  wire start_ok = mode.run && (mode.trigger_source_bit ? ext_trigger_input : armed_reg);
  wire last_bit = trial_bit_reg[0];
  wire finish   = state_reg == sac_pkg::SAC_DECIDE && step_end && last_bit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sac_pkg::SAC_IDLE:   if (start_ok) state_next = sac_pkg::SAC_SAMPLE;
      sac_pkg::SAC_SAMPLE: if (step_end) state_next = sac_pkg::SAC_DECIDE;
      sac_pkg::SAC_DECIDE: if (finish) state_next = (mode.trigger_source_bit) ? sac_pkg::SAC_IDLE
                                                             : sac_pkg::SAC_SAMPLE;
      default:             state_next = sac_pkg::SAC_IDLE;
    endcase
    if (wr_mode) state_next = sac_pkg::SAC_IDLE;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= sac_pkg::SAC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // software start armed by a mode write with run set; hardware waits for trigger
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
    end else if (wr_mode) begin
      armed_reg <= reg_wdata[sac_pkg::SAC_RUN_BIT] && !reg_wdata[sac_pkg::SAC_TRG_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg <= 8'h00;
    end else if (fx_tick || state_reg == sac_pkg::SAC_IDLE) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // step timer, successive approximation
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_reg     <= 8'h00;
      approx_shift_reg <= 8'h00;
      trial_bit_reg    <= 8'h00;
    end else if (state_next == sac_pkg::SAC_SAMPLE && state_reg != sac_pkg::SAC_SAMPLE) begin
      step_cnt_reg     <= sample_len - 8'h01;
      approx_shift_reg <= 8'h80;
      trial_bit_reg    <= 8'h80;
    end else if (state_reg == sac_pkg::SAC_SAMPLE && step_end) begin
      step_cnt_reg <= bit_len - 8'h01;
    end else if (state_reg == sac_pkg::SAC_DECIDE && step_end) begin
      step_cnt_reg <= bit_len - 8'h01;
      // keep trial bit if input at or above tap, then try next lower bit
      approx_shift_reg <= (comparator_out ? approx_shift_reg : (approx_shift_reg & ~trial_bit_reg))
                          | (trial_bit_reg >> 1);
      trial_bit_reg    <= trial_bit_reg >> 1;
    end else if (fx_tick && step_cnt_reg != 8'h00) begin
      step_cnt_reg <= step_cnt_reg - 8'h01;
    end
  end

  // ============================================================
  // registers
  wire [7:0] final_code = comparator_out ? approx_shift_reg : (approx_shift_reg & ~trial_bit_reg);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conv_mode_reg         <= sac_pkg::SAC_MODE_RESET;
      analog_pin_select_reg <= sac_pkg::SAC_PINSEL_RESET;
    end else begin
      if (wr_mode) conv_mode_reg <= reg_wdata;
      if (wr_pinsel) analog_pin_select_reg <= reg_wdata;
    end
  end

  // result has no reset: undefined until first conversion
  always_ff @(posedge clk_sys) begin
    if (finish && !wr_mode) conv_result_reg <= final_code;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= finish && !wr_mode;
    end
  end

  wire [7:0] rdata_next = !reg_rd   ? 8'h00 :
                          rd_mode   ? conv_mode_reg :
                          rd_result ? conv_result_reg :
                          rd_pinsel ? analog_pin_select_reg : 8'h00;

  // ============================================================
  // outputs, all registered
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata      <= 8'h00;
      tap_code       <= 8'h00;
      analog_channel <= 3'h0;
      sample_hold    <= 1'b0;
      analog_power   <= 1'b0;
      analog_pin_en  <= 8'h00;
      pullup_en      <= 8'h00;
    end else begin
      reg_rdata      <= rdata_next;
      tap_code       <= approx_shift_reg;
      analog_channel <= mode.ch;
      sample_hold    <= state_reg == sac_pkg::SAC_SAMPLE;
      analog_power   <= mode.run;
      analog_pin_en  <= analog_pin_select_reg;
      pullup_en      <= port_pullup_req & ~analog_pin_select_reg;
    end
  end
endmodule // sac_adc_ctrl

// >>> sac_pkg.sv
// constants and types for the successive-approximation converter control block
// ============================================================
// Summary of operation
// - eight selectable analog channels, each conversion yields an eight-bit code
// - successive-approximation search; final code held in eight-bit result register
// - hardware-start mode begins conversion on external trigger input
// - software-start mode begins when mode register written with run bit set
// - hardware-started converter stops after a single conversion
// - software-started converter repeats conversions back to back
// - done interrupt request raised every time a conversion finishes
// - resolve bits from msb using comparator, copy to result after lsb
// - result loaded at each conversion end, read as a byte, undefined after reset
// - pins not selected as analog remain usable as port pins
// - mode register resets to one, only the high-speed time bit set
// - mode layout: run, trigger, time select 5-4, channel 3-1, high-speed bit 0
// - three-bit channel field selects input by its binary value
// - time-select bits give conversion length in main clock periods; others prohibited
// - trigger bit zero selects software start, one selects hardware start
// - run bit zero stops conversion, one enables it
// - pin-select register resets to zero, all pins ports
// - analog-assigned pins never get the internal pull-up
// - hardware mode: no new conversion until a fresh trigger
// - write with run clear during conversion aborts it at once
// - software mode: rewrite with run set restarts with new settings
// - hardware mode: rewrite with run set abandons and awaits a new trigger
package sac_pkg;
  localparam logic [15:0] SAC_MODE_ADDR    = 16'hFF80;
  localparam logic [15:0] SAC_RESULT_ADDR  = 16'hFF81;
  localparam logic [15:0] SAC_PINSEL_ADDR  = 16'hFF84;
  localparam logic [7:0]  SAC_MODE_RESET   = 8'h01;
  localparam logic [7:0]  SAC_PINSEL_RESET = 8'h00;
  localparam int          SAC_RUN_BIT      = 7;
  localparam int          SAC_TRG_BIT      = 6;
  localparam int          SAC_FR_HI        = 5;
  localparam int          SAC_FR_LO        = 4;
  localparam int          SAC_CH_HI        = 3;
  localparam int          SAC_CH_LO        = 1;
  localparam int          SAC_HSC_BIT      = 0;
  // conversion lengths in main-oscillator periods
  localparam logic [7:0]  SAC_LEN_40  = 8'h28;
  localparam logic [7:0]  SAC_LEN_50  = 8'h32;
  localparam logic [7:0]  SAC_LEN_80  = 8'h50;
  localparam logic [7:0]  SAC_LEN_100 = 8'h64;
  localparam logic [7:0]  SAC_LEN_160 = 8'hA0;
  localparam logic [7:0]  SAC_LEN_200 = 8'hC8;
  localparam int          SAC_BITS    = 8;

  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_DECIDE = 2'b11,
    SAC_WAIT   = 2'b10
  } sac_state_e;

  typedef struct packed {
    logic       run;
    logic       trigger_source_bit;
    logic [1:0] fr;
    logic [2:0] ch;
    logic       high_speed_time_bit;
  } sac_mode_s;
endpackage

// >>> sac_adc_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module sac_adc_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // register access
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // converter and pins
  input wire logic [2:0]  analog_channel,
  input wire logic        sample_hold,
  input wire logic        analog_power,
  input wire logic [7:0]  analog_pin_en,
  input wire logic [7:0]  pullup_en,
  input wire logic        conv_done_irq
);
  // ============================================================
  // decode
  wire wm = reg_wr && reg_addr == sac_pkg::SAC_MODE_ADDR;
  wire wp = reg_wr && reg_addr == sac_pkg::SAC_PINSEL_ADDR;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ============================================================
  // assertions
  a_irq_one_cycle: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("done pulse longer than one cycle");
  // mode register lands on the write edge, the pin copy one edge later
  a_power_run_bit: assert property (wm |=> ##1 analog_power == $past(reg_wdata[7], 2))
    else $error("power does not follow run bit");
  a_channel_field: assert property (wm |=> ##1 analog_channel == $past(reg_wdata[3:1], 2))
    else $error("channel differs from mode field");
  a_pin_select_copy: assert property (wp |=> ##1 analog_pin_en == $past(reg_wdata, 2))
    else $error("pin enable differs from written select");
  a_no_analog_pullup: assert property ($stable(analog_pin_en) [*2] |-> (pullup_en & analog_pin_en) == 8'h00)
    else $error("pull-up on analog pin");
  // any mode write kills the running conversion, including its finish cycle
  a_write_aborts: assert property (wm |=> !conv_done_irq [*8])
    else $error("done pulse after mode write");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_done_needs_run: assert property (conv_done_irq |-> analog_power)
    else $error("done pulse while stopped");
  a_hold_not_done: assert property (sample_hold |-> !conv_done_irq)
    else $error("done pulse during sampling");
  // ============================================================
  // covers
  c_last_channel: cover property (conv_done_irq && analog_channel == 3'h7);
  c_hw_arm: cover property (wm && reg_wdata[6] && reg_wdata[7]);
  c_stop: cover property ($fell(analog_power));
endmodule // sac_adc_chk

bind sac_adc_ctrl sac_adc_chk chk (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .analog_channel, .sample_hold, .analog_power, .analog_pin_en, .pullup_en, .conv_done_irq);

// >>> sac_analog_src.sv
// analog sources and comparator facing the tap selector
`timescale 1ns/1ps
module sac_analog_src #(
  parameter logic [63:0] LEVELS = 64'h0  // one byte per channel, channel 0 lowest
) (
  // clock
  input wire logic       clk_sys,
  // tap selector side
  input wire logic [7:0] tap_code,
  input wire logic [2:0] analog_channel,
  // comparator
  output logic           comparator_out = 1'b0
);
  // ============================================================
  // one when the input is at or above the tap, settled well before the step ends
  always @(posedge clk_sys) comparator_out <= LEVELS[analog_channel*8+:8] >= tap_code;
endmodule // sac_analog_src

// >>> sar_adc_controller_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_controller_tb;
  // ============================================================
  // signals
  localparam logic [63:0] LV = 64'hFFA55A3CC3817E00;
  logic        clk_sys, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, osc_mode_bit = 1'b1;
  logic        ext_trigger_input = 1'b0, comparator_out, sample_hold, analog_power, conv_done_irq;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, port_pullup_req = 8'hFF, reg_rdata, tap_code, analog_pin_en, pullup_en;
  logic [2:0]  analog_channel;
  int          fails = 0, checks_done = 0;
  // fx equals the system clock so the 80-period setting takes 80 cycles
  sac_adc_ctrl #(.OSC_DIV(1)) dut (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .osc_mode_bit, .port_pullup_req, .ext_trigger_input, .comparator_out, .tap_code, .analog_channel,
    .sample_hold, .analog_power, .analog_pin_en, .pullup_en, .conv_done_irq);
  sac_analog_src #(.LEVELS(LV)) src (.clk_sys, .tap_code, .analog_channel, .comparator_out);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ============================================================
  // tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    chk(n, reg_rdata, e);
  endtask
  task automatic irq(input int n, input logic e, input string s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge clk_sys);
      hit = conv_done_irq === 1'b1;
    end
    chk(s, {7'h00, hit}, {7'h00, e});
  endtask
  task automatic trig();
    @(posedge clk_sys);
    ext_trigger_input <= 1'b1;
    @(posedge clk_sys);
    ext_trigger_input <= 1'b0;
  endtask
  task automatic results();
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // tests
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(sac_pkg::SAC_MODE_ADDR, 8'h01, "mode reset");
    rchk(sac_pkg::SAC_PINSEL_ADDR, 8'h00, "pinsel reset");
    rchk(16'hFF90, 8'h00, "unmapped read");
    wr(sac_pkg::SAC_PINSEL_ADDR, 8'h0F);
    repeat (2) @(negedge clk_sys);
    chk("pin enable", analog_pin_en, 8'h0F);
    chk("pull-up", pullup_en, 8'hF0);
    wr(sac_pkg::SAC_PINSEL_ADDR, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      wr(sac_pkg::SAC_MODE_ADDR, {4'b1000, c[2:0], 1'b0});
      irq(100, 1'b1, "soft done");
      chk("channel", {5'h00, analog_channel}, c[7:0]);
      rchk(sac_pkg::SAC_RESULT_ADDR, LV[c*8+:8], "result");
    end
    irq(100, 1'b1, "repeat done");
    rchk(sac_pkg::SAC_RESULT_ADDR, 8'hFF, "repeat result");
    repeat (30) @(posedge clk_sys);
    wr(sac_pkg::SAC_MODE_ADDR, 8'h82);
    irq(100, 1'b1, "restart done");
    rchk(sac_pkg::SAC_RESULT_ADDR, 8'h7E, "restart result");
    rchk(sac_pkg::SAC_MODE_ADDR, 8'h82, "mode readback");
    repeat (30) @(posedge clk_sys);
    wr(sac_pkg::SAC_MODE_ADDR, 8'h02);
    irq(200, 1'b0, "stopped");
    rchk(sac_pkg::SAC_RESULT_ADDR, 8'h7E, "kept result");
    chk("power off", {7'h00, analog_power}, 8'h00);
    @(posedge clk_sys);
    osc_mode_bit <= 1'b0;
    wr(sac_pkg::SAC_MODE_ADDR, 8'h80);
    irq(140, 1'b0, "long early");
    irq(60, 1'b1, "long done");
    @(posedge clk_sys);
    osc_mode_bit <= 1'b1;
    wr(sac_pkg::SAC_MODE_ADDR, 8'hCA);
    irq(150, 1'b0, "armed idle");
    trig();
    irq(100, 1'b1, "hard done");
    rchk(sac_pkg::SAC_RESULT_ADDR, 8'h5A, "hard result");
    irq(200, 1'b0, "single shot");
    trig();
    repeat (30) @(posedge clk_sys);
    wr(sac_pkg::SAC_MODE_ADDR, 8'hCA);
    irq(150, 1'b0, "abandoned");
    trig();
    irq(100, 1'b1, "fresh trigger");
    results();
  end
  // run takes about 2000 cycles; the limit leaves ample room
  initial begin
    #200us;
    fails++;
    results();
  end
endmodule // sar_adc_controller_tb
